// *** core/bsf_seq.v ***
// Two-channel start-up and protection sequencer with an AHB-Lite register slave.
// Comparator and switching inputs are synchronous to hclk; straps are stable at reset release.
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`include "bsf_defines.vh"

module bsf_seq #(
  parameter NPH = 2,
  parameter [23:0] RST_CYC = 24'h000190,
  parameter [23:0] DLY_DEF = 24'h000fa0,
  parameter [23:0] SS_CYC = 24'h000fa0,
  parameter [23:0] GOOD_CYC = 24'h000fa0,
  parameter [23:0] HIC_CYC = 24'h009c40
) (
  input wire hclk, // Bus and sequencer clock
  input wire hresetn, // Async reset, active low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire hready, // Bus ready
  input wire [31:0] hwdata, // Write data
  output wire [31:0] hrdata, // Read data
  output wire hreadyout, // Slave ready
  output wire hresp, // Always OKAY
  input wire channel_one_enable, // Channel 1 enable
  input wire channel_two_enable, // Channel 2 enable
  input wire internal_supply_ok, // Internal supply good
  input wire stage_ready, // Power stages ready
  input wire second_delay_mode_pin, // High unless grounded
  input wire [2:0] soft_start_sel, // Soft-start strap code
  input wire [1:0] overvolt_level_one, // Level one comparator
  input wire [1:0] overvolt_level_two, // Level two comparator
  input wire [1:0] overvolt_clear, // Feedback 20 mV under level one
  input wire [1:0] undervolt_trip, // Under-voltage comparator
  input wire [1:0] ot_trip_cfg1, // Temperature trip, mode 1
  input wire [1:0] ot_trip_cfg2, // Temperature trip, mode 2
  input wire [1:0] ot_release_cfg1, // Below reset level, mode 1
  input wire [1:0] ot_release_cfg2, // Below reset level, mode 2
  input wire [1:0] cycle_tick, // Switching cycle start pulse
  input wire [2*NPH-1:0] pwm_req, // Modulator on request
  input wire [2*NPH-1:0] overcurrent_trip, // Per-phase current limit
  input wire [2*NPH-1:0] neg_current, // Low-side negative limit
  output wire [2*NPH-1:0] high_side_cmd, // High-side switch on
  output wire [2*NPH-1:0] low_side_cmd, // Low-side switch on
  output wire [1:0] power_good_out, // Power good per channel
  output wire [1:0] soft_start_active, // Output ramp running
  output wire memory_rail_mode // Memory-rail mode latched
);

  localparam [6:0] S_OFF = 7'h01;
  localparam [6:0] S_RST = 7'h02;
  localparam [6:0] S_DLY = 7'h04;
  localparam [6:0] S_SS = 7'h08;
  localparam [6:0] S_PGD = 7'h10;
  localparam [6:0] S_RUN = 7'h20;
  localparam [6:0] S_HIC = 7'h40;
  localparam integer OV_CYC_N = `BSF_OV_DEB_CYC;
  localparam integer UV_CYC_N = `BSF_UV_DEB_CYC;
  localparam integer NEG_CYC_N = `BSF_NEG_OFF_CYC;
  localparam [5:0] OV_CYC = OV_CYC_N[5:0];
  localparam [5:0] UV_CYC = UV_CYC_N[5:0];
  localparam [1:0] NEG_CYC = NEG_CYC_N[1:0];

  // Straps, caught once after reset release
  reg strap_done_q;
  reg mem_q;
  reg [2:0] ss_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      mem_q <= 1'b0;
      ss_q <= 3'h0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      mem_q <= ~second_delay_mode_pin;
      ss_q <= soft_start_sel;
    end
  end

  assign memory_rail_mode = mem_q;

  // AHB-Lite slave, zero wait states
  reg [23:0] first_delay_pin_q;
  reg [23:0] dly2_q;
  reg wr_q;
  reg [7:0] waddr_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  wire [31:0] stat_w;
  wire acc = hsel & htrans[1] & hready;

  always @* begin
    rdata_d = 32'h0;
    if (haddr[7:0] == `BSF_FIRST_DELAY_PIN_OFS) begin
      rdata_d = {8'h00, first_delay_pin_q};
    end else if (haddr[7:0] == `BSF_DLY2_OFS) begin
      rdata_d = {8'h00, dly2_q};
    end else if (haddr[7:0] == `BSF_STAT_OFS) begin
      rdata_d = stat_w;
    end
    // A write still in its data phase would otherwise read back stale
    if (wr_q && waddr_q == haddr[7:0] &&
        (waddr_q == `BSF_FIRST_DELAY_PIN_OFS || waddr_q == `BSF_DLY2_OFS)) begin
      rdata_d = {8'h00, hwdata[23:0]};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0;
      first_delay_pin_q <= DLY_DEF;
      dly2_q <= DLY_DEF;
    end else begin
      wr_q <= acc & hwrite;
      waddr_q <= haddr[7:0];
      rdata_q <= (acc & ~hwrite & (haddr[31:8] == 24'h0)) ? rdata_d : 32'h0;
      if (wr_q && waddr_q == `BSF_FIRST_DELAY_PIN_OFS) begin
        first_delay_pin_q <= hwdata[23:0];
      end else if (wr_q && waddr_q == `BSF_DLY2_OFS) begin
        dly2_q <= hwdata[23:0];
      end
    end
  end

  assign hrdata = rdata_q;
  // Kept in flops so every bus output leaves a register
  reg ready_q;
  reg resp_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  assign hreadyout = ready_q;
  assign hresp = resp_q;

  wire [1:0] hic_req;
  wire [1:0] ok_w = {channel_two_enable, channel_one_enable} & {2{internal_supply_ok & stage_ready}};

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg [6:0] st_q, st_d;
      reg [23:0] cnt_q, cnt_d;
      reg ov1_q, ov1_d, ov2_q, ov2_d;
      wire ov1_deb, ov2_deb, uv_deb;
      reg [1:0] ng_q [0:NPH-1];
      reg [NPH-1:0] ocs_q, ocs_d;
      reg [3:0] occ_q, occ_d;
      reg otp_q, otp_d;
      reg [NPH-1:0] hs_q, hs_d, ls_q, ls_d;
      reg pg_q, ssa_q;
      wire [NPH-1:0] pwm = pwm_req[c*NPH +: NPH];
      wire [NPH-1:0] oci = overcurrent_trip[c*NPH +: NPH];
      wire [NPH-1:0] neg = neg_current[c*NPH +: NPH];
      wire arm_a = |(st_q & (S_SS | S_PGD | S_RUN));
      wire arm_b = st_q == S_RUN;
      wire trip1 = arm_b & ov1_deb;
      wire trip2 = arm_a & ov2_deb;
      wire uvt = arm_b & uv_deb;
      wire ot_in = ss_q[2] ? ot_trip_cfg2[c] : ot_trip_cfg1[c];
      wire ot_rel = ss_q[2] ? ot_release_cfg2[c] : ot_release_cfg1[c];
      wire ott = arm_a & ot_in;
      wire all_oc = &(ocs_q | oci);
      wire oct = arm_a & cycle_tick[c] & all_oc & (occ_q == `BSF_OC_CYCLES);
      wire [23:0] dly = (c == 1 && !mem_q) ? dly2_q : first_delay_pin_q;
      wire [23:0] ss_len = SS_CYC << ss_q[1:0];
      wire go_hic = arm_a & (hic_req[c] | (mem_q & hic_req[1-c]));
      integer p;

      assign hic_req[c] = uvt | oct | ott;

      always @* begin
        st_d = st_q;
        cnt_d = cnt_q + 24'd1;
        otp_d = ott | (otp_q & ~ot_rel);
        ocs_d = cycle_tick[c] ? oci : (ocs_q | oci);
        occ_d = occ_q;
        if (cycle_tick[c]) begin
          occ_d = (all_oc && occ_q != `BSF_OC_CYCLES) ? occ_q + 4'd1 : (all_oc ? occ_q : 4'd0);
        end
        ov1_d = trip1 | (ov1_q & ~overvolt_clear[c]);
        ov2_d = trip2 | (ov2_q & ~overvolt_clear[c]);
        case (st_q)
          S_OFF: begin
            cnt_d = 24'd0;
            if (strap_done_q) begin
              st_d = S_RST;
            end
          end
          S_RST: begin
            if (cnt_q >= RST_CYC - 24'd1) begin
              st_d = S_DLY;
              cnt_d = 24'd0;
            end
          end
          S_DLY: begin
            if (cnt_q >= dly) begin
              st_d = S_SS;
              cnt_d = 24'd0;
            end
          end
          S_SS: begin
            if (cnt_q >= ss_len - 24'd1) begin
              st_d = S_PGD;
              cnt_d = 24'd0;
            end
          end
          S_PGD: begin
            if (cnt_q >= GOOD_CYC - 24'd1) begin
              st_d = S_RUN;
              cnt_d = 24'd0;
            end
          end
          S_RUN: begin
            cnt_d = 24'd0;
          end
          S_HIC: begin
            if (cnt_q >= HIC_CYC - 24'd1) begin
              cnt_d = cnt_q;
              if (!otp_q || ot_rel) begin
                st_d = S_RST;
                cnt_d = 24'd0;
              end
            end
          end
          default: begin
            st_d = S_OFF;
            cnt_d = 24'd0;
          end
        endcase
        if (go_hic) begin
          st_d = S_HIC;
          cnt_d = 24'd0;
        end
        if (!ok_w[c]) begin
          st_d = S_OFF;
          cnt_d = 24'd0;
        end
        if (!(|(st_d & (S_SS | S_PGD | S_RUN)))) begin
          // Disarmed outside soft start, power-good delay and run
          ov1_d = 1'b0;
          ov2_d = 1'b0;
          occ_d = 4'd0;
        end
        for (p = 0; p < NPH; p = p + 1) begin
          hs_d[p] = 1'b0;
          ls_d[p] = 1'b0;
          if (|(st_d & (S_SS | S_PGD | S_RUN))) begin
            if (ov2_d) begin
              ls_d[p] = 1'b1;
            end else if (ov1_d) begin
              ls_d[p] = ~neg[p] & (ng_q[p] == 2'd0);
            end else begin
              hs_d[p] = pwm[p] & ~(ocs_d[p]);
              ls_d[p] = ~pwm[p];
            end
          end
        end
      end

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_q <= S_OFF;
          cnt_q <= 24'd0;
          ov1_q <= 1'b0;
          ov2_q <= 1'b0;
          ocs_q <= {NPH{1'b0}};
          occ_q <= 4'd0;
          otp_q <= 1'b0;
          hs_q <= {NPH{1'b0}};
          ls_q <= {NPH{1'b0}};
          pg_q <= 1'b0;
          ssa_q <= 1'b0;
        end else begin
          st_q <= st_d;
          cnt_q <= cnt_d;
          ov1_q <= ov1_d;
          ov2_q <= ov2_d;
          ocs_q <= ocs_d;
          occ_q <= occ_d;
          otp_q <= otp_d;
          hs_q <= hs_d;
          ls_q <= ls_d;
          pg_q <= (st_d == S_RUN) & ~ov1_d & ~ov2_d & ~uvt;
          ssa_q <= st_d == S_SS;
        end
      end

      bsf_deb #(.W(6), .LIM(OV_CYC)) i_deb_ov1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(overvolt_level_one[c]),
        .done(ov1_deb)
      );

      bsf_deb #(.W(6), .LIM(OV_CYC)) i_deb_ov2 (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(overvolt_level_two[c]),
        .done(ov2_deb)
      );

      bsf_deb #(.W(6), .LIM(UV_CYC)) i_deb_uv (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(undervolt_trip[c]),
        .done(uv_deb)
      );

      genvar q;
      for (q = 0; q < NPH; q = q + 1) begin : g_ph
        // Blanking held in ov1 only; ov2 ignores negative current
        always @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            ng_q[q] <= 2'd0;
          end else if (neg[q] && ov1_q && !ov2_q) begin
            ng_q[q] <= NEG_CYC - 2'd1;
          end else if (ng_q[q] != 2'd0) begin
            ng_q[q] <= ng_q[q] - 2'd1;
          end
        end
      end

      assign high_side_cmd[c*NPH +: NPH] = hs_q;
      assign low_side_cmd[c*NPH +: NPH] = ls_q;
      assign power_good_out[c] = pg_q;
      assign soft_start_active[c] = ssa_q;
      assign stat_w[c*16 +: 16] = {4'h0, mem_q, otp_q, ov2_q, ov1_q, pg_q, st_q};
    end
  endgenerate

endmodule

// Saturating debounce; trips one cycle past the time
module bsf_deb #(
  parameter W = 6,
  parameter [W-1:0] LIM = 6'd40
) (
  input wire hclk, // Clock
  input wire hresetn, // Async reset, active low
  input wire level, // Comparator level
  output wire done // Level held past the limit
);

  reg [W-1:0] cnt_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= {W{1'b0}};
    end else if (!level) begin
      cnt_q <= {W{1'b0}};
    end else if (cnt_q != LIM) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Any dip restarts the count, so only a continuous level trips
  assign done = level & (cnt_q == LIM);

endmodule

// *** core/bsf_defines.vh ***
// Constants for the buck start and fault sequencer.
// Assumes a single 40 MHz clock; the debounce and blanking counts are derived from it.
`ifndef BSF_DEFINES_VH
`define BSF_DEFINES_VH

`define BSF_CLK_KHZ 40000
// Debounce and blanking times in ns
`define BSF_OV_DEB_NS 1000
`define BSF_UV_DEB_NS 1500
`define BSF_NEG_OFF_NS 50
// Longest debounce rounds down, least off time rounds up
`define BSF_OV_DEB_CYC ((`BSF_OV_DEB_NS * `BSF_CLK_KHZ) / 1000000)
`define BSF_UV_DEB_CYC ((`BSF_UV_DEB_NS * `BSF_CLK_KHZ) / 1000000)
`define BSF_NEG_OFF_CYC ((`BSF_NEG_OFF_NS * `BSF_CLK_KHZ + 999999) / 1000000)
// Switching cycles of all-phase over-current tolerated before hiccup
`define BSF_OC_CYCLES 4'd8

// Register byte offsets
`define BSF_FIRST_DELAY_PIN_OFS 8'h00
`define BSF_DLY2_OFS 8'h04
`define BSF_STAT_OFS 8'h08

// Status fields: channel c occupies bits c*16 + field
`define BSF_ST_STATE_LSB 0
`define BSF_ST_PG_BIT 7
`define BSF_ST_OV1_BIT 8
`define BSF_ST_OV2_BIT 9
`define BSF_ST_OTP_BIT 10
`define BSF_ST_MEM_BIT 11

`define BSF_DLY_W 24
`endif

// *** verif/bsf_seq_sva.sv ***
// Pin-level assertions for the sequencer, channel one.
// Assumes one clock and the bench's power stage model.
module bsf_seq_sva #(
  parameter NPH = 2,
  parameter [23:0] RST_CYC = 24'h000190,
  parameter [23:0] SS_CYC = 24'h000fa0
) (
  input wire hclk, // Clock
  input wire hresetn, // Reset
  input wire channel_one_enable, // Enable
  input wire internal_supply_ok, // Supply
  input wire stage_ready, // Stages
  input wire [2:0] soft_start_sel, // Strap
  input wire [1:0] overvolt_level_one, // OV one
  input wire [1:0] overvolt_level_two, // OV two
  input wire [1:0] overvolt_clear, // Clear
  input wire [1:0] undervolt_trip, // UV
  input wire [2*NPH-1:0] neg_current, // Sink
  input wire [2*NPH-1:0] high_side_cmd, // Highs
  input wire [2*NPH-1:0] low_side_cmd, // Lows
  input wire [1:0] power_good_out, // Good
  input wire [1:0] soft_start_active, // Ramp
  input wire memory_rail_mode // Mode
);
  timeunit 1ns;
  timeprecision 100ps;
  wire ok = channel_one_enable & internal_supply_ok & stage_ready;
  logic [6:0] c1_q, c2_q, cu_q;
  logic [7:0] ok_q, ss_q;
  logic [1:0] up_q;
  logic h1_q, h2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {c1_q, c2_q, cu_q, ok_q, ss_q, up_q, h1_q, h2_q} <= '0;
    end else begin
      c1_q <= overvolt_level_one[0] ? c1_q + 7'h1 : 7'h0;
      c2_q <= overvolt_level_two[0] ? c2_q + 7'h1 : 7'h0;
      cu_q <= undervolt_trip[0] ? cu_q + 7'h1 : 7'h0;
      ok_q <= !ok ? 8'h0 : ok_q + {7'h0, ok_q != 8'hff};
      ss_q <= soft_start_active[0] ? ss_q + 8'h1 : 8'h0;
      up_q <= up_q + {1'b0, up_q != 2'h3};
      // Mirrors of the trip flags; set beats clear
      h1_q <= (c1_q == 7'd40 && overvolt_level_one[0] && power_good_out[0]) ||
        (h1_q && ok && !overvolt_clear[0]);
      h2_q <= (c2_q == 7'd40 && overvolt_level_two[0] && (power_good_out[0] || h1_q)) ||
        (h2_q && ok && !overvolt_clear[0]);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ov1_trip: assert property (h1_q |-> !power_good_out[0] && high_side_cmd[NPH-1:0] == '0)
    else $error("level one trip left good or high side on");
  a_ov1_blank: assert property (h1_q && !h2_q && neg_current[0] |=> !low_side_cmd[0] [*2])
    else $error("negative limit blanking too short");
  a_ov2_hold: assert property (h2_q |-> high_side_cmd[NPH-1:0] == '0 && &low_side_cmd[NPH-1:0])
    else $error("level two trip switch states wrong");
  a_uv_off: assert property (cu_q == 7'd60 && undervolt_trip[0] && power_good_out[0] |=>
    !power_good_out[0] && high_side_cmd[NPH-1:0] == '0 && low_side_cmd[NPH-1:0] == '0)
    else $error("under-voltage did not turn all off");
  a_off_lost: assert property (!ok |=> !power_good_out[0] && !soft_start_active[0])
    else $error("channel runs without enable");
  a_ss_late: assert property ($rose(soft_start_active[0]) |-> {16'h0, ok_q} > RST_CYC)
    else $error("soft start began too early");
  a_ss_len: assert property ($fell(soft_start_active[0]) && ok |->
    {16'h0, ss_q} == (SS_CYC << soft_start_sel[1:0]))
    else $error("soft start length wrong");
  a_pg_late: assert property (power_good_out[0] |-> !soft_start_active[0])
    else $error("good during soft start");
  a_mode_hold: assert property (up_q == 2'h3 |-> $stable(memory_rail_mode))
    else $error("memory mode changed after start");
  cover property (h1_q && neg_current[0]);
  cover property (h2_q && neg_current[0]);
  cover property ($rose(power_good_out[0]));
endmodule

bind bsf_seq bsf_seq_sva #(.NPH(NPH), .RST_CYC(RST_CYC), .SS_CYC(SS_CYC)) i_sva (.hclk,
  .hresetn, .channel_one_enable, .internal_supply_ok, .stage_ready, .soft_start_sel,
  .overvolt_level_one, .overvolt_level_two, .overvolt_clear, .undervolt_trip, .neg_current,
  .high_side_cmd, .low_side_cmd, .power_good_out, .soft_start_active, .memory_rail_mode);

// *** verif/bsf_stage_model.sv ***
// Power stage model: modulator timing and current sensing per phase.
// Assumes registered switch commands from the sequencer.
module bsf_stage_model #(
  parameter NPH = 2
) (
  input wire hclk, // Clock
  input wire hresetn, // Reset
  input wire [2*NPH-1:0] high_side_cmd, // Highs
  input wire [2*NPH-1:0] low_side_cmd, // Lows
  input wire oc_force, // Overload
  input wire neg_force, // Sink
  output logic [1:0] cycle_tick, // Period start
  output logic [2*NPH-1:0] pwm_req, // On request
  output logic [2*NPH-1:0] overcurrent_trip, // Limit
  output logic [2*NPH-1:0] neg_current // Negative
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] ph_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= ph_q + 3'h1;
    end
  end
  // Current flows only through a switch that is on; overload hits channel one
  always_comb begin
    cycle_tick = {2{ph_q == 3'h0}};
    pwm_req = {2*NPH{ph_q < 3'h4}};
    overcurrent_trip = oc_force ? {{NPH{1'b0}}, high_side_cmd[NPH-1:0]} : '0;
    neg_current = neg_force ? low_side_cmd : '0;
  end
endmodule

// *** verif/tb_bsf_seq.sv ***
// Bench for the sequencer: bus tasks, fault stimuli, power stage model.
// Assumes shortened durations so each start-up takes a few dozen cycles.
module tb_bsf_seq;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, oc_force = 0, neg_force = 0;
  logic channel_one_enable = 0, channel_two_enable = 0, internal_supply_ok = 0;
  logic stage_ready = 0, second_delay_mode_pin = 1;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0] htrans = '0, overvolt_level_one = '0, overvolt_level_two = '0, overvolt_clear = '0;
  logic [1:0] undervolt_trip = '0, ot_trip_cfg1 = '0, ot_trip_cfg2 = '0, ot_release_cfg1 = '0;
  logic [1:0] ot_release_cfg2 = '0;
  logic [2:0] soft_start_sel = '0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, memory_rail_mode;
  wire [1:0] cycle_tick, power_good_out, soft_start_active;
  wire [3:0] pwm_req, overcurrent_trip, neg_current, high_side_cmd, low_side_cmd;
  int fails = 0, samples_checked = 0;
  bsf_seq #(.RST_CYC(24'h4), .DLY_DEF(24'h4), .SS_CYC(24'h8), .GOOD_CYC(24'h8), .HIC_CYC(24'h10))
    i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .channel_one_enable, .channel_two_enable,
    .internal_supply_ok, .stage_ready, .second_delay_mode_pin, .soft_start_sel,
    .overvolt_level_one, .overvolt_level_two, .overvolt_clear, .undervolt_trip, .ot_trip_cfg1,
    .ot_trip_cfg2, .ot_release_cfg1, .ot_release_cfg2, .cycle_tick, .pwm_req,
    .overcurrent_trip, .neg_current, .high_side_cmd, .low_side_cmd, .power_good_out,
    .soft_start_active, .memory_rail_mode);
  bsf_stage_model i_stg (.hclk, .hresetn, .high_side_cmd, .low_side_cmd, .oc_force, .neg_force,
    .cycle_tick, .pwm_req, .overcurrent_trip, .neg_current);
  initial forever #12.5 hclk = ~hclk;
  task automatic test_done();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic rdy();
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (++n > 20) begin
        fails++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // Bounded wait for both good outputs to reach a value
  task automatic wpg(input logic [1:0] e, input int lim);
    int n = 0;
    while (power_good_out !== e) begin
      if (++n > lim) begin
        fails++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask
  task automatic start(input logic m);
    hresetn <= 1'b0;
    {channel_one_enable, channel_two_enable, internal_supply_ok, stage_ready} <= 4'h0;
    second_delay_mode_pin <= m;
    soft_start_sel <= m ? 3'h0 : 3'h1;
    cyc(10);
    hresetn <= 1'b1;
    cyc(2);
  endtask
  task automatic go();
    {channel_one_enable, channel_two_enable, internal_supply_ok, stage_ready} <= 4'hf;
  endtask
  // Sink current stops before the clear so no blanking is pending
  task automatic ovclr();
    {neg_force, overvolt_level_one, overvolt_level_two} <= 5'h0;
    cyc(3);
    overvolt_clear <= 2'b01;
    cyc(1);
    overvolt_clear <= 2'b00;
    cyc(3);
  endtask
  initial begin
    start(1'b1);
    rd(8'h00, 32'h4);
    rd(8'h40, 32'h0);
    wr(8'h08, 32'hffffffff);
    wr(8'h04, 32'hff000006);
    rd(8'h04, 32'h6);
    go();
    wpg(2'b11, 500);
    rd(8'h08, 32'h00a000a0);
    neg_force <= 1'b1;
    overvolt_level_one <= 2'b01;
    cyc(45);
    rd(8'h08, 32'h00a00120);
    ovclr();
    rd(8'h08, 32'h00a000a0);
    {overvolt_level_one, overvolt_level_two} <= 4'h5;
    cyc(45);
    neg_force <= 1'b1;
    cyc(6);
    rd(8'h08, 32'h00a00320);
    ovclr();
    ot_trip_cfg2 <= 2'b01;
    cyc(5);
    rd(8'h08, 32'h00a000a0);
    ot_trip_cfg2 <= 2'b00;
    ot_trip_cfg1 <= 2'b01;
    cyc(2);
    ot_trip_cfg1 <= 2'b00;
    cyc(40);
    rd(8'h08, 32'h00a00440);
    ot_release_cfg1 <= 2'b01;
    wpg(2'b11, 500);
    ot_release_cfg1 <= 2'b00;
    undervolt_trip <= 2'b01;
    cyc(63);
    rd(8'h08, 32'h00a00040);
    undervolt_trip <= 2'b00;
    wpg(2'b11, 500);
    oc_force <= 1'b1;
    wpg(2'b10, 500);
    oc_force <= 1'b0;
    rd(8'h08, 32'h00a00040);
    start(1'b0);
    wr(8'h04, 32'h80);
    go();
    wpg(2'b11, 60);
    chk({31'h0, memory_rail_mode}, 32'h1);
    undervolt_trip <= 2'b01;
    cyc(63);
    chk({30'h0, power_good_out}, 32'h0);
    test_done();
  end
endmodule
